// ### verilog/mmio_pkg.sv
package mmio_pkg;
	// Special function register addresses
	localparam logic [7:0] ADDR_PORT0_DATA   = 8'h80;
	localparam logic [7:0] ADDR_PORT1_DATA   = 8'h90;
	localparam logic [7:0] ADDR_PORT0_DRIVE  = 8'h91;
	localparam logic [7:0] ADDR_PORT2_DRIVE  = 8'h93;
	localparam logic [7:0] ADDR_PORT2_DATA   = 8'hA0;
	localparam logic [7:0] ADDR_P1_LOW_MODE  = 8'hA2;
	localparam logic [7:0] ADDR_P1_HIGH_MODE = 8'hA3;
	localparam logic [7:0] ADDR_P3_LOW_MODE  = 8'hA4;
	localparam logic [7:0] ADDR_P3_HIGH_MODE = 8'hA5;
	localparam logic [7:0] ADDR_ROUTING      = 8'hA6;
	localparam logic [7:0] ADDR_PORT3_DATA   = 8'hB0;
	localparam logic [7:0] ADDR_P4_LOW_MODE  = 8'hB4;
	localparam logic [7:0] ADDR_P4_HIGH_MODE = 8'hB5;
	localparam logic [7:0] ADDR_SERIAL_A     = 8'hBC;
	localparam logic [7:0] ADDR_PORT5_DATA   = 8'hC0;
	localparam logic [7:0] ADDR_USB          = 8'hC1;
	localparam logic [7:0] ADDR_PORT4_DATA   = 8'hE8;
	// Reset values
	localparam logic [7:0] RST_DATA  = 8'hFF;
	localparam logic [7:0] RST_ZERO  = 8'h00;
	localparam logic [7:0] RST_PORT5 = 8'h01;
	// Field positions in the routing register
	localparam int BIT_P5_DRIVE = 7;
	localparam int BIT_PWM0_POS = 6;
	localparam int BIT_PWM0_NEG = 5;
	localparam int BIT_T2_OUT   = 4;
	localparam int BIT_T0_OUT   = 3;
	localparam int BIT_PWM1_A   = 2;
	localparam int BIT_PWM1_B   = 1;
	localparam int BIT_PWM1_C   = 0;
	// Other control bit positions
	localparam int BIT_SS_DISABLE = 3;
	localparam int BIT_USB_ENABLE = 7;
	// Pin positions of routed signals
	localparam int PIN_T2_OUT  = 0;
	localparam int PIN_USB_DP  = 2;
	localparam int PIN_USB_DM  = 3;
	localparam int PIN_PWM0_P  = 4;
	localparam int PIN_PWM1_A  = 5;
	localparam int PIN_T0_OUT  = 4;
	localparam int PIN_WEAK_HI = 2;
	// Timer output division ratios
	localparam int T0_DIVIDE = 64;
	localparam int T2_DIVIDE = 2;
	// Strong high kick length in clocks (1 to 2 allowed)
	localparam int KICK_CYCLES = 2;
	// Pin mode encoding
	typedef enum logic [1:0] {
		MMIO_MODE_PULLUP = 2'h0,
		MMIO_MODE_OPEN   = 2'h1,
		MMIO_MODE_PUSH   = 2'h2,
		MMIO_MODE_ALT    = 2'h3
	} mmio_mode_e;
endpackage : mmio_pkg

// ### verilog/mmio_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
// Toggles output every DIV/2 overflow pulses, giving overflow divided by DIV
module mmio_clkdiv #(
	parameter int DIV = 2
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// Overflow pulse in, divided clock out
	input  wire logic ovf_pulse,
	output logic      div_out
);
	localparam int HALF = DIV / 2;
	localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);

	// Odd or tiny ratios cannot be built from a single toggle flop
	if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
		$error("mmio_clkdiv: DIV must be even and >= 2");
	end

	logic [CW-1:0] cnt_q; // Overflows since last toggle

	// Count overflows, toggle at half period
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q   <= '0;
			div_out <= 1'b0;
		end else if (ovf_pulse) begin
			if (cnt_q == LAST) begin
				cnt_q   <= '0;
				div_out <= ~div_out;
			end else begin
				cnt_q <= cnt_q + CW'(1);
			end
		end
	end
endmodule // mmio_clkdiv
`default_nettype wire

// ### verilog/mmio_pin.sv
`timescale 1ns/1ps
`default_nettype none
// Pad control for one mode-selectable pin of Port1, Port3 or Port4
module mmio_pin #(
	parameter bit WEAK_KICK = 1'b0 // Pin has the pseudo open drain kick
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// Control
	input  wire logic [1:0] mode,
	input  wire logic       data_bit,
	input  wire logic       route_en,   // Routed internal signal active
	input  wire logic       route_val,
	input  wire logic       usb_take,   // USB owns the pad
	// Pad controls
	output logic            pin_o,
	output logic            pin_oe,
	output logic            pull_up,
	output logic            in_en
);
	logic drive_val;    // Value seen by the driver
	logic kick_need;
	logic prev_q;       // Last driven value for edge detect
	logic [1:0] kick_q; // Remaining strong-high cycles

	// Routed signal replaces the data bit
	assign drive_val = route_en ? route_val : data_bit;

	// Low-to-high on a weak pin starts the strong kick
	assign kick_need = WEAK_KICK && !prev_q && drive_val &&
		(mode == mmio_pkg::MMIO_MODE_PULLUP || mode == mmio_pkg::MMIO_MODE_OPEN);

	// Kick counter; the edge cycle itself is the first strong cycle, so the
	// total never exceeds KICK_CYCLES
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 1'b1;
			kick_q <= 2'h0;
		end else begin
			prev_q <= drive_val;
			if (kick_need)
				kick_q <= 2'(mmio_pkg::KICK_CYCLES - 1);
			else if (kick_q != 2'h0)
				kick_q <= kick_q - 2'h1;
		end
	end

	// Pad decode per mode
	always_comb begin
		pin_o   = 1'b0;
		pin_oe  = 1'b0;
		pull_up = 1'b0;
		in_en   = 1'b0;
		if (usb_take) begin
			// USB transceiver owns it; port logic hands off
			in_en = 1'b0;
		end else begin
			case (mode)
				mmio_pkg::MMIO_MODE_PULLUP: begin
					pin_oe  = !drive_val || kick_need || kick_q != 2'h0;
					pin_o   = drive_val;
					pull_up = drive_val;
					in_en   = drive_val;
				end
				mmio_pkg::MMIO_MODE_OPEN: begin
					// Plain open drain only gets the kick on weak pins
					pin_oe = !drive_val || kick_need || kick_q != 2'h0;
					pin_o  = drive_val;
					in_en  = drive_val;
				end
				mmio_pkg::MMIO_MODE_PUSH: begin
					pin_oe = 1'b1;
					pin_o  = drive_val;
				end
				mmio_pkg::MMIO_MODE_ALT: begin
					pin_oe = 1'b0;
				end
				default: begin
					pin_oe = 1'b0;
				end
			endcase
		end
	end
endmodule // mmio_pin
`default_nettype wire

// ### verilog/mmio_port_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Port data, mode and routing registers on the SFR bus, plus pad control
module mmio_port_mux (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// SFR bus from the CPU
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd,
	input  wire logic        sfr_rmw,    // Read is a read-modify-write operand
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,    // Address belongs to this block
	// Internal signals to route
	input  wire logic        timer0_ovf,
	input  wire logic        timer2_ovf,
	input  wire logic        pwm0_positive_output,
	input  wire logic        pwm0_negative_output,
	input  wire logic [2:0]  pwm1_out,   // Channels C,B,A in bits 2,1,0
	// Status to other blocks
	output logic             usb_pins_enable,
	output logic             spi_chip_select_input,
	output logic             spi_cs_active,
	output logic      [6:0]  usb_function_address,
	// Mode-selectable pins, index 0..7 per port
	input  wire logic [7:0]  p1_i,
	output logic      [7:0]  p1_o,
	output logic      [7:0]  p1_oe,
	output logic      [7:0]  p1_pu,
	input  wire logic [7:0]  p3_i,
	output logic      [7:0]  p3_o,
	output logic      [7:0]  p3_oe,
	output logic      [7:0]  p3_pu,
	input  wire logic [7:0]  p4_i,
	output logic      [7:0]  p4_o,
	output logic      [7:0]  p4_oe,
	output logic      [7:0]  p4_pu,
	// Direction-controlled pins
	input  wire logic [7:0]  p0_i,
	output logic      [7:0]  p0_o,
	output logic      [7:0]  p0_oe,
	output logic      [7:0]  p0_pu,
	input  wire logic [7:0]  p2_i,
	output logic      [7:0]  p2_o,
	output logic      [7:0]  p2_oe,
	output logic      [7:0]  p2_pu,
	input  wire logic        p5_i,
	output logic             p5_o,
	output logic             p5_oe,
	output logic             p5_pu
);
	// Software-visible registers
	logic [7:0]  p0_data_q, p1_data_q, p2_data_q, p3_data_q, p4_data_q;
	logic        p5_data_q;
	logic [7:0]  p0_drv_q, p2_drv_q;       // Direction, one is output
	logic [15:0] p1_mode_q, p3_mode_q, p4_mode_q; // Two bits per pin
	logic [7:0]  route_q;                  // Output routing bits
	logic [7:0]  spi_ctl_q;                // Serial A control
	logic [7:0]  usb_q;                    // USB enable and address
	// Synchronised pin levels (first stage read only by second)
	logic [40:0] pin_meta_q, pin_sync_q;
	// Divided timer clocks
	logic t0_clk, t2_clk;
	// Per-pin input enables from pad decode
	logic [7:0] p1_in_en, p3_in_en, p4_in_en;

	// Decode write strobe for one address
	function automatic logic wr_hit(input logic [7:0] a);
		return sfr_wr && sfr_addr == a;
	endfunction

	// Port data registers; the CPU writes whole bytes, bit ops are done by the CPU core
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			p0_data_q <= mmio_pkg::RST_DATA;
			p1_data_q <= mmio_pkg::RST_DATA;
			p2_data_q <= mmio_pkg::RST_DATA;
			p3_data_q <= mmio_pkg::RST_DATA;
			p4_data_q <= mmio_pkg::RST_DATA;
			p5_data_q <= mmio_pkg::RST_PORT5[0];
		end else begin
			if (wr_hit(mmio_pkg::ADDR_PORT0_DATA)) p0_data_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_PORT1_DATA)) p1_data_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_PORT2_DATA)) p2_data_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_PORT3_DATA)) p3_data_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_PORT4_DATA)) p4_data_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_PORT5_DATA)) p5_data_q <= sfr_wdata[0];
		end
	end

	// Direction registers, every pin starts as input
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			p0_drv_q <= mmio_pkg::RST_ZERO;
			p2_drv_q <= mmio_pkg::RST_ZERO;
		end else begin
			if (wr_hit(mmio_pkg::ADDR_PORT0_DRIVE)) p0_drv_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_PORT2_DRIVE)) p2_drv_q <= sfr_wdata;
		end
	end

	// Mode registers, low register holds pins 3..0, high holds 7..4
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			p1_mode_q <= {mmio_pkg::RST_ZERO, mmio_pkg::RST_ZERO};
			p3_mode_q <= {mmio_pkg::RST_ZERO, mmio_pkg::RST_ZERO};
			p4_mode_q <= {mmio_pkg::RST_ZERO, mmio_pkg::RST_ZERO};
		end else begin
			if (wr_hit(mmio_pkg::ADDR_P1_LOW_MODE))  p1_mode_q[7:0]  <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_P1_HIGH_MODE)) p1_mode_q[15:8] <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_P3_LOW_MODE))  p3_mode_q[7:0]  <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_P3_HIGH_MODE)) p3_mode_q[15:8] <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_P4_LOW_MODE))  p4_mode_q[7:0]  <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_P4_HIGH_MODE)) p4_mode_q[15:8] <= sfr_wdata;
		end
	end

	// Routing, serial control and USB registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			route_q   <= mmio_pkg::RST_ZERO;
			spi_ctl_q <= mmio_pkg::RST_ZERO;
			usb_q     <= mmio_pkg::RST_ZERO;
		end else begin
			if (wr_hit(mmio_pkg::ADDR_ROUTING))   route_q   <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_SERIAL_A))  spi_ctl_q <= sfr_wdata;
			if (wr_hit(mmio_pkg::ADDR_USB))       usb_q     <= sfr_wdata;
		end
	end

	// Two-flop synchroniser on every pin level
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_q <= '1;
			pin_sync_q <= '1;
		end else begin
			pin_meta_q <= {p5_i, p4_i, p3_i, p2_i, p1_i, p0_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	// Timer clock outputs
	mmio_clkdiv #(.DIV(mmio_pkg::T0_DIVIDE)) u_t0_div (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.ovf_pulse (timer0_ovf),
		.div_out   (t0_clk)
	);
	mmio_clkdiv #(.DIV(mmio_pkg::T2_DIVIDE)) u_t2_div (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.ovf_pulse (timer2_ovf),
		.div_out   (t2_clk)
	);

	// Port1 pins: timer2, PWM0 positive, PWM1 A/B/C and USB pair
	generate
		for (genvar n = 0; n < 8; n++) begin : g_p1
			logic ren, rval;
			if (n == mmio_pkg::PIN_T2_OUT) begin : g_t2
				assign ren  = route_q[mmio_pkg::BIT_T2_OUT];
				assign rval = t2_clk;
			end else if (n == mmio_pkg::PIN_PWM0_P) begin : g_pwm0
				assign ren  = route_q[mmio_pkg::BIT_PWM0_POS];
				assign rval = pwm0_positive_output;
			end else if (n >= mmio_pkg::PIN_PWM1_A) begin : g_pwm1
				// Channel A on pin 5 uses bit 2, C on pin 7 uses bit 0
				assign ren  = route_q[mmio_pkg::BIT_PWM1_A - (n - mmio_pkg::PIN_PWM1_A)];
				assign rval = pwm1_out[n - mmio_pkg::PIN_PWM1_A];
			end else begin : g_none
				assign ren  = 1'b0;
				assign rval = 1'b0;
			end
			mmio_pin #(.WEAK_KICK(1'b0)) u_pin (
				.mclk      (mclk),
				.reset_n   (reset_n),
				.mode      (p1_mode_q[2*n +: 2]),
				.data_bit  (p1_data_q[n]),
				.route_en  (ren),
				.route_val (rval),
				.usb_take  (usb_pins_enable && (n == mmio_pkg::PIN_USB_DP ||
					n == mmio_pkg::PIN_USB_DM)),
				.pin_o     (p1_o[n]),
				.pin_oe    (p1_oe[n]),
				.pull_up   (p1_pu[n]),
				.in_en     (p1_in_en[n])
			);
		end
	endgenerate

	// Port3 pins: pins 0..2 weak pull-up kick, pin 4 timer0 clock
	generate
		for (genvar n = 0; n < 8; n++) begin : g_p3
			mmio_pin #(.WEAK_KICK(n <= mmio_pkg::PIN_WEAK_HI)) u_pin (
				.mclk      (mclk),
				.reset_n   (reset_n),
				.mode      (p3_mode_q[2*n +: 2]),
				.data_bit  (p3_data_q[n]),
				.route_en  ((n == mmio_pkg::PIN_T0_OUT) &&
					route_q[mmio_pkg::BIT_T0_OUT]),
				.route_val (t0_clk),
				.usb_take  (1'b0),
				.pin_o     (p3_o[n]),
				.pin_oe    (p3_oe[n]),
				.pull_up   (p3_pu[n]),
				.in_en     (p3_in_en[n])
			);
		end
	endgenerate

	// Port4 pins: plain port function
	generate
		for (genvar n = 0; n < 8; n++) begin : g_p4
			mmio_pin #(.WEAK_KICK(1'b0)) u_pin (
				.mclk      (mclk),
				.reset_n   (reset_n),
				.mode      (p4_mode_q[2*n +: 2]),
				.data_bit  (p4_data_q[n]),
				.route_en  (1'b0),
				.route_val (1'b0),
				.usb_take  (1'b0),
				.pin_o     (p4_o[n]),
				.pin_oe    (p4_oe[n]),
				.pull_up   (p4_pu[n]),
				.in_en     (p4_in_en[n])
			);
		end
	endgenerate

	// Port0/Port2: drive-enable one pushes data, zero senses with optional pull-up
	always_comb begin
		p0_oe = p0_drv_q;
		p0_o  = p0_data_q;
		p0_pu = ~p0_drv_q & p0_data_q;
		p2_oe = p2_drv_q;
		p2_o  = p2_data_q;
		p2_pu = ~p2_drv_q & p2_data_q;
	end

	// P5.0: PWM0 negative takes priority over the port data when routed
	always_comb begin
		if (route_q[mmio_pkg::BIT_PWM0_NEG]) begin
			p5_oe = 1'b1;
			p5_o  = pwm0_negative_output;
			p5_pu = 1'b0;
		end else begin
			p5_oe = route_q[mmio_pkg::BIT_P5_DRIVE];
			p5_o  = p5_data_q;
			p5_pu = !route_q[mmio_pkg::BIT_P5_DRIVE] && p5_data_q;
		end
	end

	// Chip-select input follows the synchronised P3.4 level while enabled
	assign spi_cs_active = !spi_ctl_q[mmio_pkg::BIT_SS_DISABLE];
	assign spi_chip_select_input = spi_cs_active ?
		pin_sync_q[24 + mmio_pkg::PIN_T0_OUT] : 1'b1;
	assign usb_pins_enable      = usb_q[mmio_pkg::BIT_USB_ENABLE];
	assign usb_function_address = usb_q[6:0];

	// Address hit decode
	always_comb begin
		case (sfr_addr)
			mmio_pkg::ADDR_PORT0_DATA, mmio_pkg::ADDR_PORT1_DATA,
			mmio_pkg::ADDR_PORT0_DRIVE, mmio_pkg::ADDR_PORT2_DRIVE,
			mmio_pkg::ADDR_PORT2_DATA, mmio_pkg::ADDR_P1_LOW_MODE,
			mmio_pkg::ADDR_P1_HIGH_MODE, mmio_pkg::ADDR_P3_LOW_MODE,
			mmio_pkg::ADDR_P3_HIGH_MODE, mmio_pkg::ADDR_ROUTING,
			mmio_pkg::ADDR_PORT3_DATA, mmio_pkg::ADDR_P4_LOW_MODE,
			mmio_pkg::ADDR_P4_HIGH_MODE, mmio_pkg::ADDR_SERIAL_A,
			mmio_pkg::ADDR_PORT5_DATA, mmio_pkg::ADDR_USB,
			mmio_pkg::ADDR_PORT4_DATA: sfr_hit = 1'b1;
			default: sfr_hit = 1'b0;
		endcase
	end

	// Read data registered; port reads pick latch or pin by the operand flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sfr_rdata <= mmio_pkg::RST_ZERO;
		end else if (sfr_rd) begin
			case (sfr_addr)
				mmio_pkg::ADDR_PORT0_DATA:
					sfr_rdata <= sfr_rmw ? p0_data_q : pin_sync_q[7:0];
				mmio_pkg::ADDR_PORT1_DATA:
					sfr_rdata <= sfr_rmw ? p1_data_q : pin_sync_q[15:8];
				mmio_pkg::ADDR_PORT2_DATA:
					sfr_rdata <= sfr_rmw ? p2_data_q : pin_sync_q[23:16];
				mmio_pkg::ADDR_PORT3_DATA:
					sfr_rdata <= sfr_rmw ? p3_data_q : pin_sync_q[31:24];
				mmio_pkg::ADDR_PORT4_DATA:
					sfr_rdata <= sfr_rmw ? p4_data_q : pin_sync_q[39:32];
				mmio_pkg::ADDR_PORT5_DATA:
					sfr_rdata <= {7'h00, sfr_rmw ? p5_data_q : pin_sync_q[40]};
				mmio_pkg::ADDR_PORT0_DRIVE:  sfr_rdata <= p0_drv_q;
				mmio_pkg::ADDR_PORT2_DRIVE:  sfr_rdata <= p2_drv_q;
				mmio_pkg::ADDR_P1_LOW_MODE:  sfr_rdata <= p1_mode_q[7:0];
				mmio_pkg::ADDR_P1_HIGH_MODE: sfr_rdata <= p1_mode_q[15:8];
				mmio_pkg::ADDR_P3_LOW_MODE:  sfr_rdata <= p3_mode_q[7:0];
				mmio_pkg::ADDR_P3_HIGH_MODE: sfr_rdata <= p3_mode_q[15:8];
				mmio_pkg::ADDR_P4_LOW_MODE:  sfr_rdata <= p4_mode_q[7:0];
				mmio_pkg::ADDR_P4_HIGH_MODE: sfr_rdata <= p4_mode_q[15:8];
				mmio_pkg::ADDR_ROUTING:      sfr_rdata <= route_q;
				mmio_pkg::ADDR_SERIAL_A:     sfr_rdata <= spi_ctl_q;
				mmio_pkg::ADDR_USB:          sfr_rdata <= usb_q;
				default:                     sfr_rdata <= mmio_pkg::RST_ZERO;
			endcase
		end
	end
endmodule // mmio_port_mux
`default_nettype wire

// ### tb/mmio_port_mux_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the port mux
module mmio_port_mux_sva (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       reset_n,
	// SFR bus
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rd,
	input wire logic       sfr_rmw,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	// Status
	input wire logic       usb_pins_enable,
	input wire logic       spi_chip_select_input,
	input wire logic       spi_cs_active,
	// Pads
	input wire logic [7:0] p1_i,
	input wire logic [7:0] p1_oe,
	input wire logic [7:0] p1_pu,
	input wire logic [7:0] p0_oe,
	input wire logic [7:0] p0_pu,
	input wire logic [7:0] p2_oe,
	input wire logic [7:0] p2_pu,
	input wire logic       p5_oe,
	input wire logic       p5_pu
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Pins held still long enough to cross the synchroniser
	sequence s_steady;
		$stable(p1_i) [*3];
	endsequence
	// Plain read of the Port1 data address
	sequence s_plain_rd;
		sfr_rd && !sfr_rmw && sfr_addr == 8'h90;
	endsequence
	a_drive_no_pull: assert property (((p0_oe & p0_pu) | (p2_oe & p2_pu)) == 8'h00
		&& !(p5_oe && p5_pu)) else $error("pull-up on while driving");
	a_dir_write: assert property (sfr_wr && sfr_addr == 8'h91 |=> p0_oe == $past(sfr_wdata))
		else $error("port0 direction not applied");
	a_pull_follow: assert property (sfr_wr && sfr_addr == 8'hA0
		|=> p2_pu == (~p2_oe & $past(sfr_wdata))) else $error("port2 pull-up wrong");
	a_unmapped_zero: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	a_sync_read: assert property (s_steady ##0 s_plain_rd |=> sfr_rdata == $past(p1_i))
		else $error("plain read not pin level");
	a_usb_take: assert property (usb_pins_enable |-> (p1_oe[3:2] | p1_pu[3:2]) == 2'h0)
		else $error("usb pins still driven");
	a_usb_bit: assert property (sfr_wr && sfr_addr == 8'hC1
		|=> usb_pins_enable == $past(sfr_wdata[7])) else $error("usb enable wrong");
	a_ss_select: assert property (sfr_wr && sfr_addr == 8'hBC
		|=> spi_cs_active == !$past(sfr_wdata[3])) else $error("chip select enable wrong");
	a_cs_idle: assert property (!spi_cs_active |-> spi_chip_select_input)
		else $error("chip select not idle");
endmodule // mmio_port_mux_sva
`default_nettype wire

// ### tb/mmio_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board around the pads: external sources, pull-ups, floating nets
module mmio_board (
	// Clock
	input  wire logic        mclk,
	// Pad controls from the device
	input  wire logic [40:0] o,
	input  wire logic [40:0] oe,
	input  wire logic [40:0] pu,
	// External sources set by the bench
	input  wire logic [40:0] ext_en,
	input  wire logic [40:0] ext,
	// Resolved pad levels
	output logic      [40:0] lvl
);
	logic [40:0] tog_q = 41'h0; // Floating nets change every cycle
	// Stale values must never pass for a real level
	always_ff @(posedge mclk) tog_q <= ~tog_q;
	// Device drive wins, then external source, then pull-up, else floating
	always_comb lvl = (oe & o) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | tog_q));
endmodule // mmio_board
`default_nettype wire

// ### tb/mmio_port_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mmio_port_mux_tb_top;
	// Bus and sources
	logic        mclk;
	logic        reset_n;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic [7:0]  sfr_wdata;
	logic        sfr_rd;
	logic        sfr_rmw;
	logic [7:0]  v;
	logic        t0_ovf;
	logic        t2_ovf;
	logic        pwm_p;
	logic        pwm_n;
	logic [2:0]  pwm1;
	logic [40:0] ext_en;
	logic [40:0] ext;
	// Outputs; pads packed p0 7:0, p1 15:8, p2 23:16, p3 31:24, p4 39:32, p5 40
	wire logic [7:0]  rdata;
	wire logic        hit;
	wire logic        usb_en;
	wire logic        cs_in;
	wire logic        cs_act;
	wire logic [6:0]  usb_adr;
	wire logic [40:0] po;
	wire logic [40:0] poe;
	wire logic [40:0] ppu;
	wire logic [40:0] lvl;
	int mismatches;
	int tests_run;
	mmio_port_mux u_dut (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(rdata),
		.sfr_hit(hit), .timer0_ovf(t0_ovf), .timer2_ovf(t2_ovf), .pwm0_positive_output(pwm_p),
		.pwm0_negative_output(pwm_n), .pwm1_out(pwm1), .usb_pins_enable(usb_en),
		.spi_chip_select_input(cs_in), .spi_cs_active(cs_act), .usb_function_address(usb_adr),
		.p0_i(lvl[7:0]), .p0_o(po[7:0]), .p0_oe(poe[7:0]), .p0_pu(ppu[7:0]),
		.p1_i(lvl[15:8]), .p1_o(po[15:8]), .p1_oe(poe[15:8]), .p1_pu(ppu[15:8]),
		.p2_i(lvl[23:16]), .p2_o(po[23:16]), .p2_oe(poe[23:16]), .p2_pu(ppu[23:16]),
		.p3_i(lvl[31:24]), .p3_o(po[31:24]), .p3_oe(poe[31:24]), .p3_pu(ppu[31:24]),
		.p4_i(lvl[39:32]), .p4_o(po[39:32]), .p4_oe(poe[39:32]), .p4_pu(ppu[39:32]),
		.p5_i(lvl[40]), .p5_o(po[40]), .p5_oe(poe[40]), .p5_pu(ppu[40]));
	mmio_board u_brd (.mclk(mclk), .o(po), .oe(poe), .pu(ppu), .ext_en(ext_en), .ext(ext),
		.lvl(lvl));
	// Free-running system clock
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t %s: %h not %h", $time, msg, seen, exp);
		end
	endtask
	// One write cycle, launched off the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'h1;
		@(negedge mclk);
		sfr_wr = 1'h0;
	endtask
	// One read; data settles the cycle after the taking edge
	task automatic rd(input logic [7:0] a, input logic m);
		@(negedge mclk);
		sfr_addr = a;
		sfr_rmw = m;
		sfr_rd = 1'h1;
		@(negedge mclk);
		sfr_rd = 1'h0;
		v = rdata;
	endtask
	task automatic rst;
		@(negedge mclk);
		reset_n = 1'h0;
		ext_en = 41'h0;
		repeat (12) @(negedge mclk);
		reset_n = 1'h1;
	endtask
	task automatic t_regs;
		logic [7:0] ra [17] = '{8'h80, 8'h90, 8'h91, 8'h93, 8'hA0, 8'hA2, 8'hA3, 8'hA4, 8'hA5,
			8'hA6, 8'hB0, 8'hB4, 8'hB5, 8'hBC, 8'hC0, 8'hC1, 8'hE8};
		logic [7:0] rv [17] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF};
		rst();
		chk(poe[7:0] | poe[23:16], 8'h00, "dir reset");
		chk(ppu[15:8] & ppu[39:32], 8'hFF, "mode0 pull");
		chk(poe[15:8] | poe[31:24] | poe[39:32], 8'h00, "mode0 released");
		foreach (ra[i]) begin
			rd(ra[i], 1'h1);
			chk(v, rv[i], "reset value");
			chk({7'h00, hit}, 8'h01, "address hit");
			wr(ra[i], 8'h5A);
			rd(ra[i], 1'h1);
			chk(v, (ra[i] == 8'hC0) ? 8'h00 : 8'h5A, "readback");
		end
		wr(8'h81, 8'h5A);
		rd(8'h81, 1'h0);
		chk(v, 8'h00, "unmapped");
		chk({7'h00, hit}, 8'h00, "unmapped hit");
	endtask
	task automatic t_mode;
		logic [2:0] e;
		rst();
		for (int m = 0; m < 4; m++) begin
			for (int d = 0; d < 2; d++) begin
				wr(8'hA2, 8'(m << 2));
				wr(8'h90, 8'(d << 1));
				e = {m == 2 || (m < 2 && d == 0), m == 2 && d == 1, m == 0 && d == 1};
				chk({5'h00, poe[9], po[9] & poe[9], ppu[9]}, {5'h00, e}, "pin mode");
			end
		end
		wr(8'hA2, 8'h55);
		wr(8'h90, 8'hFF);
		ext_en[15:8] = 8'hFF;
		ext[15:8] = 8'hA5;
		repeat (3) @(negedge mclk);
		rd(8'h90, 1'h0);
		chk(v, 8'hA5, "pin read");
		rd(8'h90, 1'h1);
		chk(v, 8'hFF, "latch read");
		wr(8'hB5, 8'hAA);
		wr(8'hE8, 8'h5F);
		chk({poe[39:36], po[39:36]}, 8'hF5, "p4 push");
	endtask
	task automatic t_kick;
		int n;
		rst();
		wr(8'hB0, 8'hFE);
		chk({6'h00, poe[24], po[24]}, 8'h02, "low drive");
		wr(8'hB0, 8'hFF);
		n = 0;
		while (poe[24] === 1'h1 && n < 8) begin
			n++;
			@(negedge mclk);
		end
		chk(8'(n >= 1 && n <= 2), 8'h01, "kick length");
		chk({7'h00, ppu[24]}, 8'h01, "weak hold");
	endtask
	task automatic t_route;
		logic [7:0] mv [3] = '{8'hAA, 8'h00, 8'h55};
		logic [3:0] s;
		logic [3:0] eo;
		rst();
		wr(8'h90, 8'h00);
		wr(8'hA6, 8'h47);
		foreach (mv[i]) begin
			wr(8'hA3, mv[i]);
			for (int k = 0; k < 2; k++) begin
				s = k ? 4'h4 : 4'hB;
				{pwm1, pwm_p} = s;
				@(negedge mclk);
				eo = (mv[i] == 8'hAA) ? 4'hF : ~s;
				chk({poe[15:12], po[15:12] & poe[15:12]}, {eo, s & eo}, "route");
				chk({4'h0, ppu[15:12]}, (mv[i] == 8'h00) ? {4'h0, s} : 8'h00, "rpull");
			end
		end
		wr(8'hA6, 8'h20);
		for (int k = 0; k < 2; k++) begin
			pwm_n = k[0];
			@(negedge mclk);
			chk({6'h00, poe[40], po[40]}, {6'h00, 1'h1, k[0]}, "neg route");
		end
	endtask
	task automatic t_timer;
		rst();
		wr(8'hA2, 8'h02);
		wr(8'hA5, 8'h02);
		wr(8'hA6, 8'h18);
		for (int k = 1; k <= 64; k++) begin
			{t0_ovf, t2_ovf} = 2'h3;
			@(negedge mclk);
			{t0_ovf, t2_ovf} = 2'h0;
			@(negedge mclk);
			chk({6'h00, po[28], po[8]}, {6'h00, 1'((k / 32) % 2), 1'(k % 2)}, "timer out");
		end
		wr(8'hA6, 8'h00);
		chk({6'h00, po[28], po[8]}, 8'h03, "port back");
	endtask
	task automatic t_usb;
		rst();
		wr(8'hA2, 8'hA0);
		wr(8'h90, 8'h00);
		chk({6'h00, poe[11:10]}, 8'h03, "dp dm drive");
		wr(8'hC1, 8'hA5);
		chk({5'h00, usb_en, poe[11:10] | ppu[11:10]}, 8'h04, "usb owns");
		chk({1'h0, usb_adr}, 8'h25, "usb address");
		wr(8'hA5, 8'h01);
		ext_en[28] = 1'h1;
		for (int k = 0; k < 2; k++) begin
			ext[28] = k[0];
			repeat (3) @(negedge mclk);
			chk({6'h00, cs_act, cs_in}, {6'h00, 1'h1, k[0]}, "chip select");
		end
		wr(8'hBC, 8'h08);
		ext[28] = 1'h0;
		repeat (3) @(negedge mclk);
		chk({6'h00, cs_act, cs_in}, 8'h01, "select off");
	endtask
	task automatic t_dir;
		rst();
		wr(8'h91, 8'hA5);
		wr(8'h80, 8'h0F);
		chk(poe[7:0], 8'hA5, "p0 dir");
		chk(po[7:0] & 8'hA5, 8'h05, "p0 level");
		chk(ppu[7:0], 8'h0A, "p0 pull");
		wr(8'h93, 8'h3C);
		wr(8'hA0, 8'h96);
		chk(ppu[23:16], 8'h82, "p2 pull");
		chk(poe[23:16], 8'h3C, "p2 dir");
		chk(po[23:16] & poe[23:16], 8'h14, "p2 level");
		wr(8'hA6, 8'h80);
		wr(8'hC0, 8'hFE);
		chk({5'h00, poe[40], po[40], ppu[40]}, 8'h04, "p5 low");
		wr(8'hA6, 8'h00);
		chk({6'h00, poe[40], ppu[40]}, 8'h00, "p5 hiz");
	endtask
	task automatic summarize;
		$display("mismatches %0d of %0d checks", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence, inputs idle at time zero
	initial begin
		mismatches = 0;
		tests_run = 0;
		{reset_n, sfr_wr, sfr_rd, sfr_rmw, t0_ovf, t2_ovf, pwm_p, pwm_n} = 8'h00;
		{sfr_addr, sfr_wdata, pwm1} = 19'h0;
		{ext_en, ext} = 82'h0;
		t_regs();
		t_mode();
		t_kick();
		t_route();
		t_timer();
		t_usb();
		t_dir();
		summarize();
	end
	// Watchdog well past the expected run of under a thousand cycles
	initial begin
		#500000;
		mismatches++;
		summarize();
	end
endmodule // mmio_port_mux_tb_top
bind mmio_port_mux mmio_port_mux_sva u_sva (.*);
`default_nettype wire
